// >>> rtl/pcm_consts.vh
// constants for the protected channel map codec
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// map and frame geometry
`define PCM_MAP_BITS      40
`define PCM_MAP_OCTETS    5
`define PCM_MIC_OCTETS    16
`define PCM_MIC_BITS      128
`define PCM_FRAME_BITS    168
`define PCM_LAST_OCTET    5'h14
`define PCM_CNT_W         5

// field positions
`define PCM_MODE_BIT      0
`define PCM_RSV1_BIT      1
`define PCM_REGION_LSB    2
`define PCM_REGION_W      5
`define PCM_SLOT0_LSB     7
`define PCM_SLOT_W        6
`define PCM_NUM_SLOTS     5
`define PCM_CHAN_W        8
`define PCM_RSV_HI_LSB    37
`define PCM_RSV_HI_W      3

// region designator limits
`define PCM_REGION_LAST   5'h0D
`define PCM_SUBGRP_FIRST  5'h10
`define PCM_SUBGRP_LAST   5'h14

// channel width codes
`define PCM_WIDTH_6MHZ    2'h0
`define PCM_WIDTH_7MHZ    2'h1
`define PCM_WIDTH_8MHZ    2'h2
`define PCM_WIDTH_RSV     2'h3

// subchannel counts per width
`define PCM_SUB_6MHZ      30
`define PCM_SUB_7MHZ      35
`define PCM_SUB_8MHZ      40
`define PCM_SUB_IDX_W     6

`endif

// >>> rtl/pcm_slot_codec.v
// one channel slot: actual channel to six-bit slot value and back
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.vh"

module pcm_slot_codec #(
  parameter CHAN_W = `PCM_CHAN_W,
  parameter SLOT_W = `PCM_SLOT_W
) (
  input  wire [CHAN_W-1:0] enc_chan_in,
  input  wire              enc_vld_in,
  input  wire [CHAN_W-1:0] base_in,
  input  wire              remap_in,
  output wire [SLOT_W-1:0] enc_slot_out,
  input  wire [SLOT_W-1:0] dec_slot_in,
  input  wire              zero_used_in,
  output wire [CHAN_W-1:0] dec_chan_out,
  output wire              dec_vld_out
);

  wire [CHAN_W-1:0] diff;
  wire [CHAN_W-1:0] slot_ext;
  wire [CHAN_W-1:0] raw_sum;

  // encode: direct number or offset from lowest region channel
  assign diff         = remap_in ? (enc_chan_in - base_in) : enc_chan_in;
  assign enc_slot_out = enc_vld_in ? diff[SLOT_W-1:0] : {SLOT_W{1'b0}};

  // decode: add region offset back, zero slot is empty unless meaningful
  assign slot_ext     = {{(CHAN_W-SLOT_W){1'b0}}, dec_slot_in};
  assign raw_sum      = slot_ext + base_in;
  assign dec_chan_out = remap_in ? raw_sum : slot_ext;
  assign dec_vld_out  = (dec_slot_in != {SLOT_W{1'b0}}) | zero_used_in;

endmodule // pcm_slot_codec
`default_nettype wire

// >>> rtl/pcm_sub_shift.v
// removes and restores the beacon's own subchannel in the 8 MHz map
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.vh"

module pcm_sub_shift #(
  parameter N     = `PCM_SUB_8MHZ,
  parameter IDX_W = `PCM_SUB_IDX_W
) (
  input  wire [N-1:0]     enc_occ_in,
  input  wire [IDX_W-1:0] own_in,
  output wire [N-2:0]     enc_map_out,
  input  wire [N-2:0]     dec_map_in,
  output wire [N-1:0]     dec_occ_out
);

  genvar i;

  // encode: drop own subchannel, higher ones move down one bit
  generate
    for (i = 0; i < N-1; i = i + 1) begin : g_enc
      assign enc_map_out[i] = (i < own_in) ? enc_occ_in[i] : enc_occ_in[i+1];
    end
  endgenerate

  // decode: inverse shift, own subchannel reported unoccupied
  assign dec_occ_out[0] = (own_in == {IDX_W{1'b0}}) ? 1'b0 : dec_map_in[0];
  generate
    for (i = 1; i < N; i = i + 1) begin : g_dec
      if (i < N-1) begin : g_mid
        assign dec_occ_out[i] = (i < own_in) ? dec_map_in[i] :
                                (i == own_in) ? 1'b0 : dec_map_in[i-1];
      end else begin : g_top
        assign dec_occ_out[i] = (i == own_in) ? 1'b0 : dec_map_in[i-1];
      end
    end
  endgenerate

endmodule // pcm_sub_shift
`default_nettype wire

// >>> rtl/pcm_codec.v
// protected channel/subchannel map encoder and decoder with integrity code room
// What this block does
// - map is exactly five octets, following the third parameter octet
// - bit 0 selects channel list (0) or subchannel list (1)
// - channel mode: encoder drives bit 1 to zero
// - channel mode: bits 2 to 6 carry the five-bit region designator
// - regions 00000 to 01101 valid; 01110 and 01111 never generated
// - codes 10000 to 10100 are sub-groups; 10101 upward reserved
// - five six-bit channel slots at bits 7, 13, 19, 25 and 31
// - small regions: channel number placed directly as six-bit value
// - large regions: slot holds channel minus lowest; decoder adds it back
// - channel mode: encoder drives bits 37 to 39 to zero
// - subchannel mode: bit 1 is lowest subchannel, higher bits go upward
// - top subchannel at bit 30, 35 or 39 for 6, 7, 8 MHz
// - subchannel bit set when a protected device centre lies inside
// - unused upper bits driven zero, not decoded as subchannels
// - 8 MHz: beacon's own subchannel is omitted from the map
// - width code 0/1/2 means 6/7/8 MHz, 3 is reserved
// - bit 0 sent first, lowest octet first
// - reserved bits ignored on receive, frame not rejected
// - sixteen-octet integrity code follows the map, supplied from outside
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.vh"

module pcm_codec #(
  parameter NSLOT = `PCM_NUM_SLOTS,
  parameter CW    = `PCM_CHAN_W
) (
  input  wire                        clock_in,
  input  wire                        rst_n_in,
  // encoder request from management
  input  wire                        enc_start_in,
  input  wire                        enc_sub_mode_in,
  input  wire [`PCM_REGION_W-1:0]    enc_region_in,
  input  wire                        enc_aggr_in,
  input  wire                        enc_remap_in,
  input  wire [CW-1:0]               enc_base_in,
  input  wire [NSLOT*CW-1:0]         enc_chan_in,
  input  wire [NSLOT-1:0]            enc_chan_vld_in,
  input  wire [1:0]                  enc_width_in,
  input  wire [`PCM_MAP_BITS-1:0]    enc_occ_in,
  input  wire [`PCM_SUB_IDX_W-1:0]   enc_own_sub_in,
  input  wire [`PCM_MIC_BITS-1:0]    enc_mic_in,
  output wire                        enc_busy_out,
  output wire                        enc_err_out,
  output wire [`PCM_MAP_BITS-1:0]    enc_map_out,
  // octet stream to the frame assembler
  output wire [7:0]                  tx_data_out,
  output wire                        tx_valid_out,
  output wire                        tx_last_out,
  input  wire                        tx_ready_in,
  // octet stream from the frame parser
  input  wire [7:0]                  rx_data_in,
  input  wire                        rx_valid_in,
  input  wire                        rx_first_in,
  input  wire [1:0]                  rx_width_in,
  input  wire [`PCM_SUB_IDX_W-1:0]   rx_own_sub_in,
  input  wire                        rx_remap_in,
  input  wire [CW-1:0]               rx_base_in,
  input  wire                        rx_zero_used_in,
  // decoded result
  output wire                        dec_done_out,
  output wire                        dec_err_out,
  output wire                        dec_sub_mode_out,
  output wire [`PCM_REGION_W-1:0]    dec_region_out,
  output wire                        dec_region_rsv_out,
  output wire [NSLOT*CW-1:0]         dec_chan_out,
  output wire [NSLOT-1:0]            dec_chan_vld_out,
  output wire [`PCM_MAP_BITS-1:0]    dec_occ_out,
  output wire [`PCM_MIC_BITS-1:0]    dec_mic_out
);

  localparam SW = `PCM_SLOT_W;
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg                        enc_st_r;
  reg [`PCM_FRAME_BITS-1:0]  tx_sh_r;
  reg [`PCM_CNT_W-1:0]       tx_cnt_r;
  reg                        tx_last_r;
  reg                        enc_err_r;
  reg [`PCM_MAP_BITS-1:0]    enc_map_r;
  reg [`PCM_MAP_BITS-1:0]    map_nxt;
  reg                        bad_nxt;

  reg [`PCM_FRAME_BITS-1:0]  rx_sh_r;
  reg [`PCM_CNT_W-1:0]       rx_cnt_r;
  reg                        rx_act_r;
  reg                        rx_full_r;
  reg                        dec_done_r;
  reg                        dec_err_r;
  reg                        dec_sub_r;
  reg [`PCM_REGION_W-1:0]    dec_region_r;
  reg                        dec_rsv_r;
  reg [NSLOT*CW-1:0]         dec_chan_r;
  reg [NSLOT-1:0]            dec_vld_r;
  reg [`PCM_MAP_BITS-1:0]    dec_occ_r;
  reg [`PCM_MIC_BITS-1:0]    dec_mic_r;
  reg [`PCM_MAP_BITS-1:0]    occ_nxt;

  wire [NSLOT*SW-1:0]        enc_slots;
  wire [NSLOT*CW-1:0]        dec_chans;
  wire [NSLOT-1:0]           dec_vlds;
  wire [`PCM_MAP_BITS-2:0]   sub8_map;
  wire [`PCM_MAP_BITS-1:0]   sub8_occ;
  wire [`PCM_MAP_BITS-1:0]   rx_map;
  wire                       region_ok;
  wire                       tx_take;
  wire                       rx_take;

  assign rx_map = rx_sh_r[`PCM_MAP_BITS-1:0];

  // five channel slots, shared between encode and decode
  genvar s;
  generate
    for (s = 0; s < NSLOT; s = s + 1) begin : g_slot
      pcm_slot_codec #(
        .CHAN_W (CW),
        .SLOT_W (SW)
      ) u_slot (
        .enc_chan_in  (enc_chan_in[s*CW +: CW]),
        .enc_vld_in   (enc_chan_vld_in[s]),
        .base_in      (enc_st_r == ST_IDLE ? enc_base_in : rx_base_in),
        .remap_in     (enc_st_r == ST_IDLE ? enc_remap_in : rx_remap_in),
        .enc_slot_out (enc_slots[s*SW +: SW]),
        .dec_slot_in  (rx_map[`PCM_SLOT0_LSB + s*SW +: SW]),
        .zero_used_in (rx_zero_used_in),
        .dec_chan_out (dec_chans[s*CW +: CW]),
        .dec_vld_out  (dec_vlds[s])
      );
    end
  endgenerate

  // own-subchannel removal for 8 MHz channels
  pcm_sub_shift #(
    .N     (`PCM_SUB_8MHZ),
    .IDX_W (`PCM_SUB_IDX_W)
  ) u_shift (
    .enc_occ_in  (enc_occ_in),
    .own_in      (enc_st_r == ST_IDLE ? enc_own_sub_in : rx_own_sub_in),
    .enc_map_out (sub8_map),
    .dec_map_in  (rx_map[`PCM_MAP_BITS-1:1]),
    .dec_occ_out (sub8_occ)
  );

  // region code legal to send: named region, or sub-group under aggregation
  assign region_ok = (enc_region_in <= `PCM_REGION_LAST) |
                     (enc_aggr_in & (enc_region_in >= `PCM_SUBGRP_FIRST) &
                      (enc_region_in <= `PCM_SUBGRP_LAST));

  // build the 40-bit map from the management request
  always @* begin
    map_nxt = {`PCM_MAP_BITS{1'b0}};
    bad_nxt = 1'b0;
    if (!enc_sub_mode_in) begin
      map_nxt[`PCM_MODE_BIT] = 1'b0;
      map_nxt[`PCM_RSV1_BIT] = 1'b0;
      map_nxt[`PCM_REGION_LSB +: `PCM_REGION_W] = enc_region_in;
      map_nxt[`PCM_SLOT0_LSB +: NSLOT*SW] = enc_slots;
      map_nxt[`PCM_RSV_HI_LSB +: `PCM_RSV_HI_W] = 3'h0;
      bad_nxt = ~region_ok;
    end else begin
      map_nxt[`PCM_MODE_BIT] = 1'b1;
      case (enc_width_in)
        `PCM_WIDTH_6MHZ: map_nxt[`PCM_SUB_6MHZ:1] = enc_occ_in[`PCM_SUB_6MHZ-1:0];
        `PCM_WIDTH_7MHZ: map_nxt[`PCM_SUB_7MHZ:1] = enc_occ_in[`PCM_SUB_7MHZ-1:0];
        `PCM_WIDTH_8MHZ: map_nxt[`PCM_MAP_BITS-1:1] = sub8_map;
        default: bad_nxt = 1'b1;
      endcase
    end
  end

  assign tx_take = (enc_st_r == ST_SEND) & tx_ready_in;

  // encoder: load map and code, then stream 21 octets lowest first
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enc_st_r  <= ST_IDLE;
      tx_sh_r   <= {`PCM_FRAME_BITS{1'b0}};
      tx_cnt_r  <= 5'h00;
      tx_last_r <= 1'b0;
      enc_err_r <= 1'b0;
      enc_map_r <= {`PCM_MAP_BITS{1'b0}};
    end else begin
      enc_err_r <= 1'b0;
      case (enc_st_r)
        ST_IDLE: begin
          if (enc_start_in) begin
            if (bad_nxt) begin
              enc_err_r <= 1'b1;
            end else begin
              enc_st_r  <= ST_SEND;
              enc_map_r <= map_nxt;
              tx_sh_r   <= {enc_mic_in, map_nxt};
              tx_cnt_r  <= 5'h00;
              tx_last_r <= 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (tx_take) begin
            tx_sh_r  <= {8'h00, tx_sh_r[`PCM_FRAME_BITS-1:8]};
            tx_cnt_r <= tx_cnt_r + 5'h01;
            tx_last_r <= (tx_cnt_r + 5'h01 == `PCM_LAST_OCTET);
            if (tx_last_r) begin
              enc_st_r  <= ST_IDLE;
              tx_last_r <= 1'b0;
            end
          end
        end
        default: enc_st_r <= ST_IDLE;
      endcase
    end
  end

  assign rx_take = rx_valid_in & (rx_first_in | rx_act_r);

  // receiver: collect map and code octets, lowest first
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_sh_r   <= {`PCM_FRAME_BITS{1'b0}};
      rx_cnt_r  <= 5'h00;
      rx_act_r  <= 1'b0;
      rx_full_r <= 1'b0;
    end else begin
      rx_full_r <= 1'b0;
      if (rx_take) begin
        rx_sh_r <= {rx_data_in, rx_sh_r[`PCM_FRAME_BITS-1:8]};
        if (rx_first_in) begin
          rx_cnt_r <= 5'h01;
          rx_act_r <= 1'b1;
        end else begin
          rx_cnt_r <= rx_cnt_r + 5'h01;
          if (rx_cnt_r == `PCM_LAST_OCTET) begin
            rx_act_r  <= 1'b0;
            rx_full_r <= 1'b1;
          end
        end
      end
    end
  end

  // subchannel occupancy from the received map, upper bits ignored
  always @* begin
    occ_nxt = {`PCM_MAP_BITS{1'b0}};
    case (rx_width_in)
      `PCM_WIDTH_6MHZ: occ_nxt[`PCM_SUB_6MHZ-1:0] = rx_map[`PCM_SUB_6MHZ:1];
      `PCM_WIDTH_7MHZ: occ_nxt[`PCM_SUB_7MHZ-1:0] = rx_map[`PCM_SUB_7MHZ:1];
      `PCM_WIDTH_8MHZ: occ_nxt = sub8_occ;
      default: occ_nxt = {`PCM_MAP_BITS{1'b0}};
    endcase
  end

  // decoder: register the interpretation one cycle after the last octet
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dec_done_r   <= 1'b0;
      dec_err_r    <= 1'b0;
      dec_sub_r    <= 1'b0;
      dec_region_r <= 5'h00;
      dec_rsv_r    <= 1'b0;
      dec_chan_r   <= {NSLOT*CW{1'b0}};
      dec_vld_r    <= {NSLOT{1'b0}};
      dec_occ_r    <= {`PCM_MAP_BITS{1'b0}};
      dec_mic_r    <= {`PCM_MIC_BITS{1'b0}};
    end else begin
      dec_done_r <= rx_full_r;
      if (rx_full_r) begin
        dec_sub_r <= rx_map[`PCM_MODE_BIT];
        dec_mic_r <= rx_sh_r[`PCM_FRAME_BITS-1:`PCM_MAP_BITS];
        if (!rx_map[`PCM_MODE_BIT]) begin
          // bits 1 and 37..39 never looked at
          dec_region_r <= rx_map[`PCM_REGION_LSB +: `PCM_REGION_W];
          dec_rsv_r    <= (rx_map[`PCM_REGION_LSB +: `PCM_REGION_W] > `PCM_REGION_LAST) &
                          ((rx_map[`PCM_REGION_LSB +: `PCM_REGION_W] < `PCM_SUBGRP_FIRST) |
                           (rx_map[`PCM_REGION_LSB +: `PCM_REGION_W] > `PCM_SUBGRP_LAST));
          dec_chan_r   <= dec_chans;
          dec_vld_r    <= dec_vlds;
          dec_occ_r    <= {`PCM_MAP_BITS{1'b0}};
          dec_err_r    <= 1'b0;
        end else begin
          dec_region_r <= 5'h00;
          dec_rsv_r    <= 1'b0;
          dec_chan_r   <= {NSLOT*CW{1'b0}};
          dec_vld_r    <= {NSLOT{1'b0}};
          dec_occ_r    <= occ_nxt;
          dec_err_r    <= (rx_width_in == `PCM_WIDTH_RSV);
        end
      end
    end
  end

  // outputs straight from flops
  assign enc_busy_out       = enc_st_r;
  assign enc_err_out        = enc_err_r;
  assign enc_map_out        = enc_map_r;
  assign tx_data_out        = tx_sh_r[7:0];
  assign tx_valid_out       = enc_st_r;
  assign tx_last_out        = tx_last_r;
  assign dec_done_out       = dec_done_r;
  assign dec_err_out        = dec_err_r;
  assign dec_sub_mode_out   = dec_sub_r;
  assign dec_region_out     = dec_region_r;
  assign dec_region_rsv_out = dec_rsv_r;
  assign dec_chan_out       = dec_chan_r;
  assign dec_chan_vld_out   = dec_vld_r;
  assign dec_occ_out        = dec_occ_r;
  assign dec_mic_out        = dec_mic_r;

endmodule // pcm_codec
`default_nettype wire

// >>> verif/pcm_codec_props.sv
// port assertions for the protected channel map codec
`timescale 1ns/100ps
`default_nettype none
module pcm_codec_props (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        enc_start_in,
  input wire logic        enc_busy_out,
  input wire logic        enc_err_out,
  input wire logic [39:0] enc_map_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_last_out,
  input wire logic        tx_ready_in,
  input wire logic        dec_done_out,
  input wire logic        dec_err_out,
  input wire logic        dec_sub_mode_out,
  input wire logic [4:0]  dec_region_out,
  input wire logic        dec_region_rsv_out,
  input wire logic [39:0] dec_occ_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // encoder answers a start with a frame or a refusal
  start_answer_a: assert property (
    enc_start_in && !enc_busy_out |=> tx_valid_out ^ enc_err_out) else $error("start not answered");
  octet_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("octet dropped during stall");
  first_octet_a: assert property (
    $rose(tx_valid_out) |-> tx_data_out == enc_map_out[7:0] && !tx_last_out)
    else $error("first octet is not map bits 7 to 0");
  frame_end_a: assert property (
    tx_valid_out && tx_last_out && tx_ready_in |=> !tx_valid_out) else $error("frame runs past last");
  chan_rsv_a: assert property (
    tx_valid_out && !enc_map_out[0] |-> !enc_map_out[1] && enc_map_out[39:37] == 3'h0)
    else $error("reserved channel map bits set");
  region_gen_a: assert property (
    tx_valid_out && !enc_map_out[0] |-> enc_map_out[6:2] <= 5'h0D ||
    (enc_map_out[6:2] >= 5'h10 && enc_map_out[6:2] <= 5'h14)) else $error("reserved region sent");
  err_pulse_a: assert property (
    enc_err_out |-> !tx_valid_out ##1 !enc_err_out) else $error("refusal not a single pulse");
  done_pulse_a: assert property (
    dec_done_out |=> !dec_done_out) else $error("done longer than one cycle");
  dec_rsv_a: assert property (
    dec_done_out |-> dec_region_rsv_out == (!dec_sub_mode_out && (dec_region_out == 5'h0E ||
    dec_region_out == 5'h0F || dec_region_out > 5'h14))) else $error("reserved region flag wrong");
  dec_err_a: assert property (
    dec_done_out && dec_err_out |-> dec_sub_mode_out && dec_occ_out == 40'h00_0000_0000)
    else $error("width error with occupancy");
  frame_c: cover property (tx_valid_out && tx_last_out && tx_ready_in);
  refuse_c: cover property (enc_err_out);
  sub_dec_c: cover property (dec_done_out && dec_sub_mode_out);
endmodule // pcm_codec_props
bind pcm_codec pcm_codec_props pcm_codec_props_inst (.clock_in, .rst_n_in, .enc_start_in,
  .enc_busy_out, .enc_err_out, .enc_map_out, .tx_data_out, .tx_valid_out, .tx_last_out,
  .tx_ready_in, .dec_done_out, .dec_err_out, .dec_sub_mode_out, .dec_region_out,
  .dec_region_rsv_out, .dec_occ_out);
`default_nettype wire

// >>> verif/pcm_mac_model.sv
// frame assembler sink and frame parser source facing the codec
`timescale 1ns/100ps
`default_nettype none
module pcm_mac_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_last_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_first_out
);
  logic       slow = 1'b0;
  integer     cnt = 0;
  integer     last_at = 0;
  logic [7:0] got [0:20];
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
  end
  // stores octets in arrival order, stalls every other cycle when slow
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
      if (tx_valid_in && tx_ready_out && cnt < 21) begin
        got[cnt] <= tx_data_in;
        cnt <= cnt + 1;
        if (tx_last_in) last_at <= cnt;
      end
    end
  end
  // sends one frame lowest octet first, idle gaps when slow
  task send(input [167:0] f);
    integer k;
    begin
      for (k = 0; k < 21; k = k + 1) begin
        @(posedge clock_in);
        rx_data_out <= f[8*k+:8];
        rx_valid_out <= 1'b1;
        rx_first_out <= (k == 0);
        if (slow) begin
          @(posedge clock_in);
          rx_valid_out <= 1'b0;
        end
      end
      @(posedge clock_in);
      rx_valid_out <= 1'b0;
      rx_first_out <= 1'b0;
      rx_data_out <= ~f[167:160];
    end
  endtask
endmodule // pcm_mac_model
`default_nettype wire

// >>> verif/pcm_codec_tb_top.sv
// self-checking bench for the protected channel map codec
`timescale 1ns/100ps
`default_nettype none
module pcm_codec_tb_top;
  reg           clock_in = 1'b0;
  reg           rst_n_in = 1'b0;
  reg           start = 1'b0, sub = 1'b0, aggr = 1'b0, rm = 1'b0, zu = 1'b0;
  reg   [4:0]   rg = 5'h06, v = 5'h17;
  reg   [7:0]   b = 8'h0E;
  reg   [39:0]  ch = 40'h2A_00_15_01_3F, oc = 40'hA5_C3F0_9E17;
  reg   [1:0]   w = 2'h0;
  reg   [5:0]   own = 6'h05;
  reg   [127:0] mic = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  reg   [167:0] fr;
  integer       fails = 0, total_checks = 0, i, cyc = 0;
  wire  [39:0]  enc_map_out, dec_chan_out, dec_occ_out;
  wire  [127:0] dec_mic_out;
  wire  [7:0]   tx_data_out, rx_data;
  wire  [4:0]   dec_region_out, dec_chan_vld_out;
  wire          enc_busy_out, enc_err_out, tx_valid_out, tx_last_out, tx_ready, rx_valid;
  wire          rx_first, dec_done_out, dec_err_out, dec_sub_mode_out, dec_region_rsv_out;

  always #20 clock_in = ~clock_in;
  pcm_codec pcm_codec_inst (.clock_in, .rst_n_in, .enc_start_in(start), .enc_sub_mode_in(sub),
    .enc_region_in(rg), .enc_aggr_in(aggr), .enc_remap_in(rm), .enc_base_in(b),
    .enc_chan_in(ch), .enc_chan_vld_in(v), .enc_width_in(w), .enc_occ_in(oc),
    .enc_own_sub_in(own), .enc_mic_in(mic), .enc_busy_out, .enc_err_out, .enc_map_out,
    .tx_data_out, .tx_valid_out, .tx_last_out, .tx_ready_in(tx_ready), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_first_in(rx_first), .rx_width_in(w), .rx_own_sub_in(own),
    .rx_remap_in(rm), .rx_base_in(b), .rx_zero_used_in(zu), .dec_done_out, .dec_err_out,
    .dec_sub_mode_out, .dec_region_out, .dec_region_rsv_out, .dec_chan_out,
    .dec_chan_vld_out, .dec_occ_out, .dec_mic_out);
  pcm_mac_model pcm_mac_model_inst (.clock_in, .rst_n_in, .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_first_out(rx_first));

  // subchannel count and whether subchannel n is carried
  function automatic logic carried(input integer n);
    carried = n < ((w == 2'h0) ? 30 : (w == 2'h1) ? 35 : 40) && !(w == 2'h2 && n == own);
  endfunction
  // expected map from the request fields
  function automatic [39:0] emap();
    integer n, j;
    reg [7:0] s;
    begin
      emap = 40'h00_0000_0000;
      j = 1;
      if (!sub) begin
        emap[6:2] = rg;
        for (n = 0; n < 5; n = n + 1) begin
          s = v[n] ? ch[8*n+:8] - (rm ? b : 8'h00) : 8'h00;
          emap[7+6*n+:6] = s[5:0];
        end
      end else begin
        emap[0] = 1'b1;
        for (n = 0; n < 40; n = n + 1)
          if (carried(n)) begin
            emap[j] = oc[n];
            j = j + 1;
          end
      end
    end
  endfunction
  task chk(input logic ok, input string msg);
    begin
      total_checks = total_checks + 1;
      if (!ok) begin
        fails = fails + 1;
        $display("[ERR] %0t %s", $time, msg);
      end
    end
  endtask
  task stop_test;
    begin
      if (fails == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // feeds a frame to the decoder and checks the result
  task rx(input [167:0] f);
    integer n;
    begin
      pcm_mac_model_inst.send(f);
      n = 0;
      // done rises the cycle after the last octet strobe drops, so it may already stand
      #1;
      while (dec_done_out !== 1'b1 && n < 40) begin
        @(posedge clock_in);
        #1;
        n = n + 1;
      end
      chk(n < 40, "no decode done");
      if (sub && w == 2'h3) chk(dec_err_out === 1'b1, "width code 3 not flagged");
      else begin
        chk(dec_sub_mode_out === sub && dec_mic_out === mic, "mode or code");
        chk(dec_err_out === 1'b0, "false width error");
        if (!sub) begin
          chk(dec_region_out === rg, "region");
          chk(dec_chan_vld_out === (v | {5{zu}}), "slot flags");
          chk(dec_region_rsv_out === (rg == 5'h0E || rg == 5'h0F || rg > 5'h14), "rsv");
          for (n = 0; n < 5; n = n + 1)
            if (v[n]) chk(dec_chan_out[8*n+:8] === ch[8*n+:8], "channel");
            else if (zu) chk(dec_chan_out[8*n+:8] === (rm ? b : 8'h00), "zero slot");
        end else
          for (n = 0; n < 40; n = n + 1)
            chk(dec_occ_out[n] === (carried(n) & oc[n]), "occupancy");
      end
    end
  endtask
  // encodes one map, checks refusal or the sent frame, then decodes it
  task run(input logic bad);
    integer n;
    reg [167:0] f;
    begin
      @(posedge clock_in);
      start <= 1'b1;
      pcm_mac_model_inst.cnt = 0;
      pcm_mac_model_inst.last_at = 0;
      f = {mic, emap()};
      @(posedge clock_in);
      start <= 1'b0;
      #1;
      chk(enc_err_out === bad, "start refusal");
      chk(enc_busy_out === !bad, "busy after start");
      if (!bad) begin
        n = 0;
        while (pcm_mac_model_inst.cnt < 21 && n < 200) begin
          @(posedge clock_in);
          #1;
          n = n + 1;
        end
        chk(n < 200, "frame stalled");
        chk(enc_busy_out === 1'b0, "busy after frame");
        chk(enc_map_out === f[39:0], "map out");
        chk(pcm_mac_model_inst.last_at == 20, "last flag position");
        for (n = 0; n < 21; n = n + 1)
          chk(pcm_mac_model_inst.got[n] === f[8*n+:8], "octet");
      end
      rx(f);
    end
  endtask
  // hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    run(1'b0);
    @(posedge clock_in);
    rm <= 1'b1;
    ch <= 40'h2A_14_33_14_44;
    pcm_mac_model_inst.slow <= 1'b1;
    run(1'b0);
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge clock_in);
      rg <= i[4:0];
      aggr <= i[5];
      run(i[4:0] == 5'h0E || i[4:0] == 5'h0F || i[4:0] > 5'h14 || (i[4] && !i[5]));
    end
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clock_in);
      sub <= 1'b1;
      w <= (i > 3) ? 2'h2 : i[1:0];
      own <= (i > 3) ? 6'h27 : 6'h05;
      run(i == 3);
    end
    @(posedge clock_in);
    w <= 2'h0;
    @(posedge clock_in);
    fr = {mic, emap()};
    fr[39:31] = 9'h1FF;
    rx(fr);
    @(posedge clock_in);
    sub <= 1'b0;
    zu <= 1'b1;
    @(posedge clock_in);
    fr = {mic, emap()};
    fr[1] = 1'b1;
    fr[39:37] = 3'h7;
    rx(fr);
    stop_test;
  end
endmodule // pcm_codec_tb_top
`default_nettype wire
